// *** hw/pirc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module pirc_ctrl #(
  parameter int unsigned TICK_CYCLES = pirc_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = pirc_pkg::DEBOUNCE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic auto_stop_contact,
  input wire logic flow_proving_switch,
  input wire logic stop_key,
  input wire logic loss_of_load,
  input wire logic [4:0] pump_delay_min,
  input wire logic [3:0] relay_setup,
  input wire logic [1:0] machine_manual_reset_diag,
  input wire logic [1:0] circuit_manual_reset_diag,
  input wire logic [1:0] machine_auto_reset_diag,
  input wire logic [1:0] circuit_auto_reset_diag,
  input wire logic [1:0] info_warning_diag,
  input wire logic [1:0] circuit_running,
  input wire logic full_capacity,
  output logic pump_run,
  output logic chiller_run,
  output logic unload_cmd,
  output logic flow_loss_diag,
  output logic [2:0] relay_out,
  output pirc_pkg::pirc_state_t state
);
  import pirc_pkg::*;

  // Diag vectors: bit 0 circuit 1, bit 1 circuit 2; machine diags hit both
  function automatic logic [1:0] alarm_pick(input logic [3:0] setup,
                                            input logic [1:0] man,
                                            input logic [1:0] aut,
                                            input logic [1:0] inf);
    logic [1:0] pos;
    pos = 2'((setup - 4'h1) % 4'(SETUPS_PER_CFG));
    alarm_pick = man | ((pos == 2'h1 || pos == 2'h2) ? aut : 2'h0)
                     | ((pos == 2'h2 || pos == 2'h3) ? inf : 2'h0);
  endfunction

  logic auto_closed, flow_ok, stop_clean;
  wire [2:0] raw_bits = {stop_key, flow_proving_switch, auto_stop_contact};
  logic [2:0] clean_bits;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_db
      pirc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db (
        .ref_clk(ref_clk),
        .rst(rst),
        .raw_in(raw_bits[gi]),
        .clean_out(clean_bits[gi])
      );
    end
  endgenerate
  assign auto_closed = clean_bits[0];
  assign flow_ok = clean_bits[1];
  assign stop_clean = clean_bits[2];

  logic stop_prev;
  logic [31:0] tick_cnt;
  logic [11:0] pump_sec;
  logic [5:0] unload_sec;
  logic stop_req;
  pirc_state_t next_state;

  wire tick = (tick_cnt == TICK_CYCLES - 1);
  wire stop_press = stop_clean && !stop_prev;
  wire [4:0] delay_clamped = (pump_delay_min < 5'(PUMP_DELAY_MIN_MIN)) ? 5'(PUMP_DELAY_MIN_MIN)
                           : (pump_delay_min > 5'(PUMP_DELAY_MAX_MIN)) ? 5'(PUMP_DELAY_MAX_MIN)
                           : pump_delay_min;
  wire [11:0] delay_sec = 12'(delay_clamped) * 12'(SEC_PER_MIN);
  wire end_cycle = stop_press || loss_of_load || !auto_closed;
  wire unload_done = (unload_sec >= 6'(UNLOAD_S));

  always_comb begin
    next_state = state;
    case (state)
      PIRC_IDLE: begin
        if (auto_closed && flow_ok && !stop_req) next_state = PIRC_RUN;
      end
      PIRC_RUN: begin
        if (!flow_ok) next_state = PIRC_TRIP;
        else if (end_cycle) next_state = PIRC_UNLOAD;
      end
      PIRC_UNLOAD: begin
        if (!flow_ok) next_state = PIRC_TRIP;
        else if (unload_done) next_state = PIRC_IDLE;
      end
      PIRC_TRIP: begin
        if (flow_ok) next_state = PIRC_IDLE; // Auto-reset on restored flow
      end
      default: next_state = PIRC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= PIRC_IDLE;
      stop_prev <= 1'b0;
      stop_req <= 1'b0;
      tick_cnt <= 32'h0000_0000;
      pump_sec <= 12'h000;
      unload_sec <= 6'h00;
    end else begin
      state <= next_state;
      stop_prev <= stop_clean;
      // Stop key latches off until auto/stop recycles, so a press is not undone at once
      if (stop_press) stop_req <= 1'b1;
      else if (!auto_closed) stop_req <= 1'b0;
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (state != PIRC_UNLOAD) unload_sec <= 6'h00;
      else if (tick && !unload_done) unload_sec <= unload_sec + 6'h01;
      if (auto_closed) pump_sec <= 12'h000;
      else if (tick && pump_sec < delay_sec) pump_sec <= pump_sec + 12'h001;
    end
  end

  // Relay mapping
  wire [1:0] alarm_c = alarm_pick(relay_setup,
    circuit_manual_reset_diag | {2{|machine_manual_reset_diag}},
    circuit_auto_reset_diag | {2{|machine_auto_reset_diag}} | {2{flow_loss_diag}},
    info_warning_diag);
  wire any_alarm = |alarm_c;
  wire cfg_one = (relay_setup >= 4'h1) && (relay_setup <= 4'h4);
  wire cfg_two = (relay_setup >= 4'h5) && (relay_setup <= 4'h8);
  wire cfg_three = (relay_setup >= 4'h9) && (relay_setup <= RELAY_SETUP_MAX);
  wire [1:0] run_c = circuit_running & {2{chiller_run}};
  wire [2:0] next_relay = cfg_one ? {full_capacity, |run_c, any_alarm}
                        : cfg_two ? {full_capacity, alarm_c[1], alarm_c[0]}
                        : cfg_three ? {run_c[1], run_c[0], any_alarm}
                        : 3'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pump_run <= 1'b0;
      chiller_run <= 1'b0;
      unload_cmd <= 1'b0;
      flow_loss_diag <= 1'b0;
      relay_out <= 3'h0;
    end else begin
      // Pump closes with auto/stop, opens only after the full delay
      pump_run <= auto_closed || (pump_run && pump_sec < delay_sec);
      chiller_run <= (next_state == PIRC_RUN) || (next_state == PIRC_UNLOAD);
      unload_cmd <= (next_state == PIRC_UNLOAD);
      flow_loss_diag <= !flow_ok && (state != PIRC_IDLE || flow_loss_diag);
      relay_out <= next_relay;
    end
  end

  int unsigned off_cnt;
  always_ff @(posedge ref_clk) begin
    if (rst || auto_closed) off_cnt <= 0;
    else if (off_cnt < 32'hFFFF_FFFF) off_cnt <= off_cnt + 1;
  end

  pump_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    auto_closed |=> pump_run) else $error("pump open while auto closed");
  pump_early_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!auto_closed && off_cnt < TICK_CYCLES) |-> ##1 pump_run || $past(!pump_run))
    else $error("pump opened before delay");
  trip_fast_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == PIRC_RUN && !flow_ok) |=> state == PIRC_TRIP)
    else $error("no immediate trip");
  trip_nounload_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == PIRC_TRIP |-> !unload_cmd) else $error("unload during trip");
  stop_unload_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == PIRC_RUN && flow_ok && !auto_closed) |=> state == PIRC_UNLOAD ##1 unload_cmd)
    else $error("auto open did not unload");
  start_run_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == PIRC_IDLE && auto_closed && flow_ok && !stop_req) |=> ##1 chiller_run)
    else $error("no start on auto close");
  unload_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state == PIRC_UNLOAD) |-> unload_sec == 6'h00)
    else $error("unload timer not restarted");
  relay_cfg_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($stable(relay_setup) && cfg_two) |=> relay_out[2] == $past(full_capacity))
    else $error("relay 3 not max capacity");
  manual_alarm_a: assert property (@(posedge ref_clk) disable iff (rst)
    (|machine_manual_reset_diag && (cfg_one || cfg_three)) |=> relay_out[0])
    else $error("manual diag missed alarm");

  run_c1: cover property (@(posedge ref_clk) disable iff (rst) state == PIRC_RUN);
  unload_c1: cover property (@(posedge ref_clk) disable iff (rst)
    state == PIRC_UNLOAD ##1 state == PIRC_IDLE);
  trip_c1: cover property (@(posedge ref_clk) disable iff (rst) $rose(flow_loss_diag));
  pump_off_c1: cover property (@(posedge ref_clk) disable iff (rst) $fell(pump_run));
endmodule // pirc_ctrl
`default_nettype wire

// *** hw/pirc_pkg.sv ***
package pirc_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
  // Unload run lasts about half a minute
  localparam int unsigned UNLOAD_S = 30;
  // Post-stop pump delay bounds, minutes
  localparam int unsigned PUMP_DELAY_MIN_MIN = 1;
  localparam int unsigned PUMP_DELAY_MAX_MIN = 30;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam logic [4:0] PUMP_DELAY_RESET = 5'h01;
  // Relay setup setting range and group size
  localparam logic [3:0] RELAY_SETUP_MIN = 4'h1;
  localparam logic [3:0] RELAY_SETUP_MAX = 4'hC;
  localparam logic [3:0] RELAY_SETUP_RESET = 4'h1;
  localparam int unsigned SETUPS_PER_CFG = 4;

  typedef enum logic [3:0] {
    PIRC_IDLE = 4'b0001,
    PIRC_RUN = 4'b0010,
    PIRC_UNLOAD = 4'b0100,
    PIRC_TRIP = 4'b1000
  } pirc_state_t;
endpackage

// *** hw/pirc_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
module pirc_debounce #(
  parameter int unsigned STABLE_CYCLES = 1_000_000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic raw_in,
  output logic clean_out
);
  logic [2:0] sync;
  logic [31:0] stable_cnt;
  wire agree = (sync[1] == sync[2]);
  wire differs = (sync[2] != clean_out);
  wire settled = (stable_cnt >= STABLE_CYCLES - 1);

  // Stage 0 only feeds stage 1; decisions use stages 1 and 2 agreeing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync <= 3'h0;
      stable_cnt <= 32'h0000_0000;
      clean_out <= 1'b0;
    end else begin
      sync <= {sync[1:0], raw_in};
      if (!agree || !differs) begin
        stable_cnt <= 32'h0000_0000;
      end else if (settled) begin
        stable_cnt <= 32'h0000_0000;
        clean_out <= sync[2];
      end else begin
        stable_cnt <= stable_cnt + 32'h0000_0001;
      end
    end
  end
endmodule // pirc_debounce
`default_nettype wire

// *** verif/pirc_field_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pirc_field_model (
  input wire logic ref_clk,
  input wire logic bas_run,
  input wire logic flow_fault,
  output logic auto_stop_contact,
  output logic flow_proving_switch
);
  initial begin
    auto_stop_contact = 1'b0;
    flow_proving_switch = 1'b1;
  end
  // Automation starts and stops the chiller only through auto/stop
  always @(negedge ref_clk) auto_stop_contact <= bas_run;
  // Primary loop keeps flow up; only a pump fault opens the switch
  always @(negedge ref_clk) flow_proving_switch <= ~flow_fault;
endmodule // pirc_field_model
`default_nettype wire

// *** verif/pump_interlock_relay_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module pump_interlock_relay_control_tb;
  import pirc_pkg::*;
  logic ref_clk, rst, bas_run, flow_fault, stop_key, loss_of_load, full_capacity;
  logic auto_stop_contact, flow_proving_switch;
  logic [4:0] pump_delay_min;
  logic [3:0] relay_setup;
  logic [1:0] mm, cm, ma, ca, iw, circuit_running;
  logic pump_run, chiller_run, unload_cmd, flow_loss_diag;
  logic [2:0] relay_out;
  pirc_state_t state;
  int n_mismatch, comparisons, cyc;
  pirc_field_model field (.ref_clk(ref_clk), .bas_run(bas_run), .flow_fault(flow_fault),
    .auto_stop_contact(auto_stop_contact), .flow_proving_switch(flow_proving_switch));
  pirc_ctrl #(.TICK_CYCLES(10), .DEBOUNCE_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst(rst),
    .auto_stop_contact(auto_stop_contact), .flow_proving_switch(flow_proving_switch),
    .stop_key(stop_key), .loss_of_load(loss_of_load), .pump_delay_min(pump_delay_min),
    .relay_setup(relay_setup), .machine_manual_reset_diag(mm),
    .circuit_manual_reset_diag(cm), .machine_auto_reset_diag(ma),
    .circuit_auto_reset_diag(ca), .info_warning_diag(iw), .circuit_running(circuit_running),
    .full_capacity(full_capacity), .pump_run(pump_run), .chiller_run(chiller_run),
    .unload_cmd(unload_cmd), .flow_loss_diag(flow_loss_diag), .relay_out(relay_out),
    .state(state));
  always #10 ref_clk = ~ref_clk;
  task automatic test_done;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the roughly 1600 cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_mismatch++;
      test_done;
    end
  end
  task automatic wc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic ws(input pirc_state_t s, input int lim);
    for (int i = 0; i < lim && state !== s; i++) wc(1);
    `CHK(state, s)
  endtask
  function automatic logic [2:0] rel(input logic [3:0] s);
    logic [3:0] k;
    logic [1:0] al;
    k = s - 4'h1;
    // Member 1,2 of a group add auto-reset; members 2,3 add warnings
    al = cm | {2{|mm}} | ((k[1] ^ k[0]) ? (ca | {2{|ma}}) : 2'b00) | (k[1] ? iw : 2'b00);
    if (s < 4'h1 || s > 4'hC) return 3'h0;
    case (k[3:2])
      2'h0: return {full_capacity, |circuit_running, |al};
      2'h1: return {full_capacity, al[1], al[0]};
      default: return {circuit_running[1], circuit_running[0], |al};
    endcase
  endfunction
  task automatic t_start;
    wc(20);
    bas_run = 1'b1;
    for (int i = 0; i < 30 && pump_run !== 1'b1; i++) wc(1);
    `CHK(state, PIRC_RUN)
    wc(1);
    `CHK(chiller_run, 1'b1)
    $display("t_start done");
  endtask
  task automatic t_relays;
    logic [9:0] tbl [6] = '{10'h000, 10'h040, 10'h200, 10'h010, 10'h008, 10'h002};
    for (int s = 0; s < 14; s++) for (int p = 0; p < 6; p++) begin
      relay_setup = 4'(s);
      {mm, cm, ma, ca, iw} = tbl[p];
      full_capacity = p[0];
      circuit_running = p[1] ? 2'b10 : 2'b01;
      wc(3);
      `CHK(relay_out, rel(4'(s)))
    end
    {mm, cm, ma, ca, iw} = 10'h000;
    $display("t_relays done");
  endtask
  task automatic t_flow;
    relay_setup = 4'h2;
    flow_fault = 1'b1;
    ws(PIRC_TRIP, 20);
    `CHK({flow_loss_diag, chiller_run, unload_cmd}, 3'b100)
    wc(2);
    `CHK(relay_out[0], 1'b1)
    flow_fault = 1'b0;
    ws(PIRC_IDLE, 20);
    `CHK(flow_loss_diag, 1'b0)
    ws(PIRC_RUN, 30);
    $display("t_flow done");
  endtask
  task automatic t_key;
    stop_key = 1'b1;
    wc(12);
    stop_key = 1'b0;
    ws(PIRC_UNLOAD, 10);
    wc(2);
    `CHK(unload_cmd, 1'b1)
    ws(PIRC_IDLE, 400);
    wc(20);
    `CHK(state, PIRC_IDLE)
    bas_run = 1'b0;
    wc(12);
    bas_run = 1'b1;
    ws(PIRC_RUN, 30);
    loss_of_load = 1'b1;
    ws(PIRC_UNLOAD, 5);
    loss_of_load = 1'b0;
    $display("t_key done");
  endtask
  task automatic t_stop;
    ws(PIRC_RUN, 400);
    bas_run = 1'b0;
    ws(PIRC_UNLOAD, 12);
    wc(270);
    `CHK(state, PIRC_UNLOAD)
    ws(PIRC_IDLE, 60);
    `CHK({chiller_run, pump_run}, 2'b01)
    wc(250);
    `CHK(pump_run, 1'b1)
    for (int i = 0; i < 80 && pump_run !== 1'b0; i++) wc(1);
    `CHK(pump_run, 1'b0)
    $display("t_stop done");
  endtask
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {bas_run, flow_fault, stop_key, loss_of_load, full_capacity} = 5'h00;
    pump_delay_min = 5'h01;
    relay_setup = 4'h1;
    {mm, cm, ma, ca, iw, circuit_running} = 12'h000;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    wc(3);
    rst = 1'b0;
    t_start;
    t_relays;
    t_flow;
    t_key;
    t_stop;
    test_done;
  end
endmodule // pump_interlock_relay_control_tb
`default_nettype wire
